// ==== design/csr_pkg.sv ====
// constants, register map and state types for the configurable shift register
package csr_pkg;
    // word width of the data input and output
    localparam int unsigned WORD_WIDTH  = 16;
    localparam int unsigned ADDR_W      = 8;
    localparam int unsigned DATA_W      = 32;
    // register byte offsets
    localparam logic [7:0]  OFS_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_INIT    = 8'h04;
    localparam logic [7:0]  OFS_SCLR    = 8'h08;
    localparam logic [7:0]  OFS_SFRC    = 8'h0c;
    localparam logic [7:0]  OFS_ACLR    = 8'h10;
    localparam logic [7:0]  OFS_AFRC    = 8'h14;
    localparam logic [7:0]  OFS_STAT    = 8'h18;
    // control field positions
    localparam int unsigned CTRL_SR_LVL = 0;
    localparam int unsigned CTRL_EDGE   = 1;
    localparam int unsigned CTRL_LEFT   = 2;
    localparam int unsigned CTRL_LOAD   = 3;
    localparam int unsigned CTRL_RELOAD = 4;
    localparam int unsigned CTRL_BITS   = 4;
    // reset values
    localparam logic [3:0]  CTRL_RST    = 4'hf;
    localparam logic [WORD_WIDTH-1:0] INIT_RST = 16'h0000;
    localparam logic [WORD_WIDTH-1:0] SCLR_RST = 16'h0000;
    localparam logic [WORD_WIDTH-1:0] SFRC_RST = 16'hffff;
    localparam logic [WORD_WIDTH-1:0] ACLR_RST = 16'h0000;
    localparam logic [WORD_WIDTH-1:0] AFRC_RST = 16'hffff;
    // bus answers
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    // bus channel states
    typedef enum logic [0:0] {WR_IDLE = 1'b0, WR_RESP = 1'b1} csr_wr_state_t;
    typedef enum logic [0:0] {RD_IDLE = 1'b0, RD_DATA = 1'b1} csr_rd_state_t;
endpackage : csr_pkg

// ==== design/csr_top.sv ====
// configurable shift register with an axi4-lite configuration port
//
// How it works
// - sync clear input at active edge loads sync_clear_value.
// - async force input loads async_force_value with no edge needed.
// - sync force input at active edge loads sync_force_value.
// - set/reset polarity bit 1 means active high, 0 active low.
// - active_edge_select picks rising or falling shift clock edge.
// - left polarity 1 shifts left on high direction, 0 inverts.
// - load polarity 1 loads on high load_shift, 0 inverts.
// - output starts at initial_output_value before any edge or set.
// - word width is a parameter of the block.
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
module csr_top
#(
    // word width
    parameter int unsigned W = csr_pkg::WORD_WIDTH
)
(
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic [csr_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [csr_pkg::DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [csr_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [csr_pkg::DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    input  wire logic                       shift_clk,
    input  wire logic                       sync_clear,
    input  wire logic                       sync_force,
    input  wire logic                       async_clear,
    input  wire logic                       async_force,
    input  wire logic                       load_shift,
    input  wire logic                       direction,
    input  wire logic                       serial_in,
    input  wire logic [W-1:0]               data_in,
    output logic [W-1:0]                    data_out
);
    import csr_pkg::*;

    // configuration registers
    logic [CTRL_BITS-1:0] ctrl_reg, ctrl_next;
    logic [W-1:0]         init_reg, init_next;
    logic [W-1:0]         sclr_reg, sclr_next;
    logic [W-1:0]         sfrc_reg, sfrc_next;
    logic [W-1:0]         aclr_reg, aclr_next;
    logic [W-1:0]         afrc_reg, afrc_next;
    logic                 reload_reg, reload_next;
    // shift core state
    logic [W-1:0]         word_reg, word_next;
    logic                 sclk_prev_reg;
    logic                 edge_hit;
    // write channel state
    csr_wr_state_t        wst_reg, wst_next;
    logic                 awready_reg, awready_next;
    logic                 wready_reg, wready_next;
    logic                 bvalid_reg, bvalid_next;
    logic [1:0]           bresp_reg, bresp_next;
    logic                 aw_have_reg, aw_have_next;
    logic                 w_have_reg, w_have_next;
    logic [ADDR_W-1:0]    aw_addr_reg, aw_addr_next;
    logic [DATA_W-1:0]    w_data_reg, w_data_next;
    logic [3:0]           w_strb_reg, w_strb_next;
    logic [DATA_W-1:0]    wmask;
    // read channel state
    csr_rd_state_t        rst_reg, rst_next;
    logic                 arready_reg, arready_next;
    logic                 rvalid_reg, rvalid_next;
    logic [DATA_W-1:0]    rdata_reg, rdata_next;
    logic [1:0]           rresp_reg, rresp_next;

    // merge a masked write into a register image
    function automatic logic [DATA_W-1:0] merge
    (
        input logic [DATA_W-1:0] old_v,
        input logic [DATA_W-1:0] new_v,
        input logic [DATA_W-1:0] mask
    );
        merge = (old_v & ~mask) | (new_v & mask);
    endfunction : merge

    // byte strobes widened to a bit mask
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_mask
            assign wmask[gi*8 +: 8] = {8{(s_axi_wvalid && wready_reg)
                ? s_axi_wstrb[gi] : w_strb_reg[gi]}};
        end
    endgenerate

    // write channel: address and data taken in either order
    always_comb
    begin
        wst_next     = wst_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        aw_have_next = aw_have_reg;
        w_have_next  = w_have_reg;
        aw_addr_next = aw_addr_reg;
        w_data_next  = w_data_reg;
        w_strb_next  = w_strb_reg;
        ctrl_next    = ctrl_reg;
        init_next    = init_reg;
        sclr_next    = sclr_reg;
        sfrc_next    = sfrc_reg;
        aclr_next    = aclr_reg;
        afrc_next    = afrc_reg;
        reload_next  = 1'b0;
        if (s_axi_awvalid && awready_reg)
        begin
            aw_have_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_reg)
        begin
            w_have_next = 1'b1;
            w_data_next = s_axi_wdata;
            w_strb_next = s_axi_wstrb;
        end
        case (wst_reg)
            WR_IDLE:
            begin
                if (aw_have_next && w_have_next)
                begin
                    aw_have_next = 1'b0;
                    w_have_next  = 1'b0;
                    bvalid_next  = 1'b1;
                    bresp_next   = RESP_OKAY;
                    wst_next     = WR_RESP;
                    case (aw_addr_next)
                        OFS_CTRL:
                        begin
                            ctrl_next = CTRL_BITS'(merge(
                                DATA_W'(ctrl_reg), w_data_next, wmask));
                            reload_next = w_data_next[CTRL_RELOAD]
                                & w_strb_next[0];
                        end
                        OFS_INIT: init_next = W'(merge(DATA_W'(init_reg),
                                      w_data_next, wmask));
                        OFS_SCLR: sclr_next = W'(merge(DATA_W'(sclr_reg),
                                      w_data_next, wmask));
                        OFS_SFRC: sfrc_next = W'(merge(DATA_W'(sfrc_reg),
                                      w_data_next, wmask));
                        OFS_ACLR: aclr_next = W'(merge(DATA_W'(aclr_reg),
                                      w_data_next, wmask));
                        OFS_AFRC: afrc_next = W'(merge(DATA_W'(afrc_reg),
                                      w_data_next, wmask));
                        OFS_STAT: bresp_next = RESP_OKAY; // read-only
                        default:  bresp_next = RESP_SLVERR;
                    endcase
                end
            end
            WR_RESP:
            begin
                if (s_axi_bready)
                begin
                    bvalid_next = 1'b0;
                    wst_next    = WR_IDLE;
                end
            end
            default: wst_next = WR_IDLE;
        endcase
        awready_next = (wst_next == WR_IDLE) && !aw_have_next;
        wready_next  = (wst_next == WR_IDLE) && !w_have_next;
    end

    // read channel: one read at a time, unmapped answers slverr
    always_comb
    begin
        rst_next     = rst_reg;
        rvalid_next  = rvalid_reg;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;
        case (rst_reg)
            RD_IDLE:
            begin
                if (s_axi_arvalid && arready_reg)
                begin
                    rvalid_next = 1'b1;
                    rresp_next  = RESP_OKAY;
                    rst_next    = RD_DATA;
                    case (s_axi_araddr)
                        OFS_CTRL: rdata_next = DATA_W'(ctrl_reg);
                        OFS_INIT: rdata_next = DATA_W'(init_reg);
                        OFS_SCLR: rdata_next = DATA_W'(sclr_reg);
                        OFS_SFRC: rdata_next = DATA_W'(sfrc_reg);
                        OFS_ACLR: rdata_next = DATA_W'(aclr_reg);
                        OFS_AFRC: rdata_next = DATA_W'(afrc_reg);
                        OFS_STAT: rdata_next = DATA_W'(word_reg);
                        default:
                        begin
                            rdata_next = '0;
                            rresp_next = RESP_SLVERR;
                        end
                    endcase
                end
            end
            RD_DATA:
            begin
                if (s_axi_rready)
                begin
                    rvalid_next = 1'b0;
                    rst_next    = RD_IDLE;
                end
            end
            default: rst_next = RD_IDLE;
        endcase
        arready_next = (rst_next == RD_IDLE);
    end

    // shift core next value, highest priority first
    always_comb
    begin
        edge_hit = ctrl_reg[CTRL_EDGE] ? (sclk_prev_reg && !shift_clk)
                                       : (!sclk_prev_reg && shift_clk);
        word_next = word_reg;
        if (async_clear == ctrl_reg[CTRL_SR_LVL])
            word_next = aclr_reg;
        else if (async_force == ctrl_reg[CTRL_SR_LVL])
            word_next = afrc_reg;
        else if (reload_reg)
            word_next = init_reg;
        else if (edge_hit)
        begin
            if (sync_clear == ctrl_reg[CTRL_SR_LVL])
                word_next = sclr_reg;
            else if (sync_force == ctrl_reg[CTRL_SR_LVL])
                word_next = sfrc_reg;
            else if (load_shift == ctrl_reg[CTRL_LOAD])
                word_next = data_in;
            else if (direction == ctrl_reg[CTRL_LEFT])
                word_next = {word_reg[W-2:0], serial_in};
            else
                word_next = {serial_in, word_reg[W-1:1]};
        end
    end

    // register all state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_reg      <= CTRL_RST;
            init_reg      <= INIT_RST;
            sclr_reg      <= SCLR_RST;
            sfrc_reg      <= SFRC_RST;
            aclr_reg      <= ACLR_RST;
            afrc_reg      <= AFRC_RST;
            reload_reg    <= 1'b0;
            word_reg      <= INIT_RST;
            sclk_prev_reg <= 1'b0;
            wst_reg       <= WR_IDLE;
            awready_reg   <= 1'b0;
            wready_reg    <= 1'b0;
            bvalid_reg    <= 1'b0;
            bresp_reg     <= RESP_OKAY;
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            aw_addr_reg   <= '0;
            w_data_reg    <= '0;
            w_strb_reg    <= '0;
            rst_reg       <= RD_IDLE;
            arready_reg   <= 1'b0;
            rvalid_reg    <= 1'b0;
            rdata_reg     <= '0;
            rresp_reg     <= RESP_OKAY;
        end
        else
        begin
            ctrl_reg      <= ctrl_next;
            init_reg      <= init_next;
            sclr_reg      <= sclr_next;
            sfrc_reg      <= sfrc_next;
            aclr_reg      <= aclr_next;
            afrc_reg      <= afrc_next;
            reload_reg    <= reload_next;
            word_reg      <= word_next;
            sclk_prev_reg <= shift_clk;
            wst_reg       <= wst_next;
            awready_reg   <= awready_next;
            wready_reg    <= wready_next;
            bvalid_reg    <= bvalid_next;
            bresp_reg     <= bresp_next;
            aw_have_reg   <= aw_have_next;
            w_have_reg    <= w_have_next;
            aw_addr_reg   <= aw_addr_next;
            w_data_reg    <= w_data_next;
            w_strb_reg    <= w_strb_next;
            rst_reg       <= rst_next;
            arready_reg   <= arready_next;
            rvalid_reg    <= rvalid_next;
            rdata_reg     <= rdata_next;
            rresp_reg     <= rresp_next;
        end
    end

    // outputs straight from flip-flops
    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign data_out      = word_reg;
endmodule : csr_top

// ==== sim/csr_chk.sv ====
// checker: shift register core actions seen at the top ports
module csr_chk
#(
    parameter int unsigned W = csr_pkg::WORD_WIDTH
)
(
    input wire logic         aclk,
    input wire logic         aresetn,
    input wire logic [7:0]   s_axi_awaddr,
    input wire logic         s_axi_awvalid,
    input wire logic         s_axi_awready,
    input wire logic [31:0]  s_axi_wdata,
    input wire logic [3:0]   s_axi_wstrb,
    input wire logic         s_axi_wvalid,
    input wire logic         s_axi_wready,
    input wire logic         shift_clk,
    input wire logic         sync_clear,
    input wire logic         sync_force,
    input wire logic         async_clear,
    input wire logic         async_force,
    input wire logic         load_shift,
    input wire logic         direction,
    input wire logic         serial_in,
    input wire logic [W-1:0] data_in,
    input wire logic [W-1:0] data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import csr_pkg::*;
    logic [W-1:0] rv [6];
    logic         sc_q, ok, wr, lv, edg, nas, nsy;
    // write handshake, active level, idle async and sync pins, active edge
    assign wr  = s_axi_awvalid && s_axi_awready
                 && s_axi_wvalid && s_axi_wready;
    assign lv  = rv[0][CTRL_SR_LVL];
    assign nas = async_clear != lv && async_force != lv;
    assign nsy = sync_clear != lv && sync_force != lv;
    assign edg = ok && (rv[0][CTRL_EDGE] ? sc_q && !shift_clk
                                         : !sc_q && shift_clk);
    // mirror of control and value registers, last clock sample
    always_ff @(posedge aclk)
    begin
        sc_q <= shift_clk;
        ok   <= aresetn;
        if (!aresetn)
            rv <= '{W'(CTRL_RST), INIT_RST, SCLR_RST, SFRC_RST, ACLR_RST,
                    AFRC_RST};
        else if (wr && s_axi_wstrb == 4'hf && s_axi_awaddr < OFS_STAT
                 && s_axi_awaddr[1:0] == 2'b00)
            rv[s_axi_awaddr[4:2]] <= s_axi_wdata[W-1:0];
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_init; disable iff (1'b0) !aresetn |=> data_out == INIT_RST;
    endproperty
    a_init: assert property (p_init) else $error("reset word wrong");
    property p_aclr; async_clear == lv |=> data_out == rv[4];
    endproperty
    a_aclr: assert property (p_aclr) else $error("clear missed");
    property p_afrc; async_clear != lv && async_force == lv
        |=> data_out == rv[5];
    endproperty
    a_afrc: assert property (p_afrc) else $error("force missed");
    property p_sclr; edg && nas && sync_clear == lv |=> data_out == rv[2];
    endproperty
    a_sclr: assert property (p_sclr) else $error("sync clear missed");
    property p_sfrc; edg && nas && sync_clear != lv && sync_force == lv
        |=> data_out == rv[3];
    endproperty
    a_sfrc: assert property (p_sfrc) else $error("sync force missed");
    property p_load; edg && nas && nsy && load_shift == rv[0][CTRL_LOAD]
        |=> data_out == $past(data_in);
    endproperty
    a_load: assert property (p_load) else $error("load missed");
    property p_left; edg && nas && nsy && load_shift != rv[0][CTRL_LOAD] &&
        direction == rv[0][CTRL_LEFT]
        |=> data_out == {$past(data_out[W-2:0]), $past(serial_in)};
    endproperty
    a_left: assert property (p_left) else $error("left shift wrong");
    property p_right; edg && nas && nsy && load_shift != rv[0][CTRL_LOAD] &&
        direction != rv[0][CTRL_LEFT]
        |=> data_out == {$past(serial_in), $past(data_out[W-1:1])};
    endproperty
    a_right: assert property (p_right) else $error("right shift wrong");
    property p_hold; !edg && nas && !wr && !$past(wr) |=> $stable(data_out);
    endproperty
    a_hold: assert property (p_hold) else $error("word moved off edge");
endmodule : csr_chk

bind csr_top csr_chk #(.W(W)) i_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .shift_clk(shift_clk), .sync_clear(sync_clear), .sync_force(sync_force),
    .async_clear(async_clear), .async_force(async_force),
    .load_shift(load_shift), .direction(direction), .serial_in(serial_in),
    .data_in(data_in), .data_out(data_out)
);

// ==== sim/csr_drv.sv ====
// surrounding logic model: shift clock, control pins and load word
module csr_drv
(
    input  wire logic        aclk,
    input  wire logic        ck,
    input  wire logic [6:0]  pv,
    input  wire logic        dv,
    input  wire logic [15:0] wd,
    output logic             shift_clk,
    output logic [6:0]       pins,
    output logic [15:0]      data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle at start: clock low, pins low
    initial
    begin
        shift_clk = 1'b0;
        pins = 7'h00;
        data_in = 16'h0000;
    end
    // launch one cycle on; a word not offered shows its inverse
    always @(posedge aclk)
    begin
        shift_clk <= ck;
        pins <= pv;
        data_in <= dv ? wd : ~data_in;
    end
endmodule : csr_drv

// ==== sim/csr_top_tb.sv ====
// self-checking bench: axi4-lite tasks and pin steps for csr_top
module csr_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import csr_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0, ck = 1'b0, dv = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, shift_clk;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0]  bresp, rresp;
    logic [6:0]  pv = 7'h00, pins;
    logic [15:0] wd = 16'h0000, data_in, data_out;
    logic [31:0] rst_tab [7] = '{32'hf, 32'h0, 32'h0, 32'hffff, 32'h0,
                                 32'hffff, 32'h0};
    int          err_count = 0;
    int          num_checks = 0;
    csr_drv i_drv (.aclk(aclk), .ck(ck), .pv(pv), .dv(dv), .wd(wd),
        .shift_clk(shift_clk), .pins(pins), .data_in(data_in));
    csr_top i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .shift_clk(shift_clk),
        .sync_clear(pins[0]), .sync_force(pins[1]), .async_clear(pins[2]),
        .async_force(pins[3]), .load_shift(pins[4]), .direction(pins[5]),
        .serial_in(pins[6]), .data_in(data_in), .data_out(data_out));
    // 125 MHz clock
    initial forever #4 aclk = ~aclk;
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    // one axi4-lite write (w=1) or read (w=0, d = expected data)
    task automatic axi(input bit w, input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] er);
        bit dn;
        dn = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        awvalid <= w;
        wvalid <= w;
        bready <= w;
        arvalid <= !w;
        rready <= !w;
        for (int n = 0; n < 64 && !dn; n++)
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (arready) arvalid <= 1'b0;
            if (bvalid || rvalid)
            begin
                dn = 1'b1;
                bready <= 1'b0;
                rready <= 1'b0;
                chk("resp", {30'h0, er}, {30'h0, (w ? bresp : rresp)});
                if (!w) chk("rdata", d, rdata);
            end
        end
        if (!dn)
        begin
            err_count++;
            print_verdict();
        end
    endtask : axi
    // set pins and shift clock level, then look at the settled word
    task automatic step(input logic [6:0] p, input logic c,
                        input logic [15:0] e);
        @(posedge aclk);
        pv <= p;
        ck <= c;
        repeat (3) @(posedge aclk);
        chk("data_out", {16'h0, e}, {16'h0, data_out});
    endtask : step
    // main sequence
    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 7; i++)
            axi(1'b0, 8'(4 * i), rst_tab[i], RESP_OKAY);
        axi(1'b0, 8'h1c, 32'h0, RESP_SLVERR);
        $display("test reset values done");
        wd <= 16'ha5c3;
        dv <= 1'b1;
        step(7'h10, 1'b1, 16'h0000);
        step(7'h10, 1'b0, 16'ha5c3);
        dv <= 1'b0;
        step(7'h60, 1'b1, 16'ha5c3);
        step(7'h60, 1'b0, 16'h4b87);
        step(7'h00, 1'b1, 16'h4b87);
        step(7'h00, 1'b0, 16'h25c3);
        $display("test load and shift done");
        axi(1'b1, OFS_SCLR, 32'h1234, RESP_OKAY);
        axi(1'b1, OFS_SFRC, 32'h5678, RESP_OKAY);
        step(7'h01, 1'b1, 16'h25c3);
        step(7'h03, 1'b0, 16'h1234);
        step(7'h02, 1'b1, 16'h1234);
        step(7'h02, 1'b0, 16'h5678);
        $display("test sync clear and force done");
        axi(1'b1, OFS_AFRC, 32'h9abc, RESP_OKAY);
        axi(1'b1, OFS_ACLR, 32'h0f0f, RESP_OKAY);
        step(7'h08, 1'b1, 16'h9abc);
        step(7'h18, 1'b0, 16'h9abc);
        step(7'h0c, 1'b1, 16'h0f0f);
        step(7'h00, 1'b1, 16'h0f0f);
        $display("test async force and clear done");
        axi(1'b1, OFS_CTRL, 32'h0, RESP_OKAY);
        wd <= 16'hc001;
        dv <= 1'b1;
        step(7'h0f, 1'b0, 16'h0f0f);
        step(7'h0f, 1'b1, 16'hc001);
        dv <= 1'b0;
        step(7'h1f, 1'b0, 16'hc001);
        step(7'h1f, 1'b1, 16'h8002);
        step(7'h3f, 1'b0, 16'h8002);
        step(7'h3f, 1'b1, 16'h4001);
        step(7'h1b, 1'b1, 16'h0f0f);
        step(7'h1f, 1'b1, 16'h0f0f);
        step(7'h1e, 1'b0, 16'h0f0f);
        step(7'h1e, 1'b1, 16'h1234);
        $display("test inverted polarities done");
        axi(1'b1, OFS_INIT, 32'h3c3c, RESP_OKAY);
        axi(1'b1, OFS_CTRL, 32'h10, RESP_OKAY);
        axi(1'b0, OFS_CTRL, 32'h0, RESP_OKAY);
        axi(1'b0, OFS_STAT, 32'h3c3c, RESP_OKAY);
        axi(1'b1, OFS_STAT, 32'h0, RESP_OKAY);
        axi(1'b1, 8'h1c, 32'h1, RESP_SLVERR);
        axi(1'b0, 8'h20, 32'h0, RESP_SLVERR);
        axi(1'b0, OFS_STAT, 32'h3c3c, RESP_OKAY);
        $display("test reload and map done");
        print_verdict();
    end
endmodule : csr_top_tb
